// *** hw/ifd_decoder.sv ***
// Instruction word decoder with cycle count control
`timescale 1ns/1ps
module ifd_decoder
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [13:0] instr_word,
   input wire logic instr_valid,
   input wire logic skip_taken,
   input wire logic [1:0] ptr_in_prog_mem,
   output logic word_taken,
   output logic instr_busy,
   output ifd_pkg::ifd_class_t instr_class,
   output logic [6:0] file_addr,
   output logic dest_is_file,
   output logic [2:0] bit_pos,
   output logic [10:0] literal,
   output logic ptr_select,
   output logic [1:0] pointer_update_mode,
   output logic indirect_access,
   output logic file_read_en,
   output logic file_write_en,
   output logic w_write_en,
   output logic [1:0] cycle_total,
   output logic [1:0] osc_phase,
   output logic cycle_end
);
   typedef enum logic [1:0]
   {
      IFD_ST_IDLE = 2'b00,
      IFD_ST_FIRST = 2'b01,
      IFD_ST_MORE = 2'b10
   } ifd_state_t;

   ifd_state_t state_q;
   logic [1:0] phase_w;
   logic cyc_end_w;
   logic [1:0] cyc_left_q;
   logic taken_q;
   logic is_skip_q;
   ifd_pkg::ifd_class_t class_q;
   logic [6:0] faddr_q;
   logic dest_q;
   logic [2:0] bpos_q;
   logic [10:0] lit_q;
   logic psel_q;
   logic [1:0] mode_q;
   logic ind_q;
   logic rd_q;
   logic wrf_q;
   logic wrw_q;
   logic [1:0] total_q;
   logic busy_q;
   logic skip_ext;
   logic accept;
   logic [1:0] base_cyc;
   logic ind_d;
   logic psel_d;
   logic extra_d;

   ifd_phase_gen u_phase
   (
      .clock(clock),
      .rst(rst),
      .phase(phase_w),
      .cycle_end(cyc_end_w)
   );

   function automatic ifd_pkg::ifd_class_t word_class(input logic [13:0] w);
      logic [5:0] op6;
      op6 = w[13:8];
      if (w[13:12] == ifd_pkg::TOP_BIT)
         word_class = ifd_pkg::IFD_CLS_BIT;
      else if (w[13:12] == ifd_pkg::TOP_MISC && w[11:7] != 5'h00)
         word_class = ifd_pkg::IFD_CLS_BYTE;
      else if (op6 == ifd_pkg::OP6_LSL || op6 == ifd_pkg::OP6_LSR ||
               op6 == ifd_pkg::OP6_ASR || op6 == ifd_pkg::OP6_SUBB ||
               op6 == ifd_pkg::OP6_ADDC)
         word_class = ifd_pkg::IFD_CLS_BYTE;
      else
         word_class = ifd_pkg::IFD_CLS_LIT;
   endfunction

   // Skip-capable words: bit tests and count-and-skip
   function automatic logic word_skips(input logic [13:0] w);
      word_skips = (w[13:10] == ifd_pkg::OP4_SKIP_CLR) ||
                   (w[13:10] == ifd_pkg::OP4_SKIP_SET) ||
                   (w[13:8] == ifd_pkg::OP6_DEC_SKIP) ||
                   (w[13:8] == ifd_pkg::OP6_INC_SKIP);
   endfunction

   // Pointer increment form carries the mode field
   function automatic logic word_ptr_inc(input logic [13:0] w);
      word_ptr_inc = (w[13:3] == ifd_pkg::OP11_PTR_INC);
   endfunction

   // Pointer offset forms carry n in bit 6
   function automatic logic word_ptr_ofs(input logic [13:0] w);
      word_ptr_ofs = (w[13:8] == ifd_pkg::OP6_PTR_OFS) ||
                     (w[13:7] == {ifd_pkg::OP6_ADD_PTR, 1'b0});
   endfunction

   function automatic logic [10:0] word_literal(input logic [13:0] w);
      if (w[13:12] == ifd_pkg::TOP_JUMP)
         word_literal = w[10:0];
      else if (w[13:7] == ifd_pkg::OP7_PAGE)
         word_literal = {4'h0, w[6:0]};
      else if (w[13:5] == ifd_pkg::OP9_BANK)
         word_literal = {6'h00, w[4:0]};
      else if (w[13:9] == ifd_pkg::OP5_REL_BRANCH)
         word_literal = {2'h0, w[8:0]};
      else if (word_ptr_ofs(w))
         word_literal = {5'h00, w[5:0]};
      else
         word_literal = {3'h0, w[7:0]};
   endfunction

   always_comb
   begin
      base_cyc = ifd_pkg::CYC_ONE;
      if (instr_word[13:11] == ifd_pkg::OP3_CALL || instr_word == ifd_pkg::OP_ACC_CALL)
         base_cyc = ifd_pkg::CYC_TWO;
      if (instr_word == ifd_pkg::OP_RETURN || instr_word == ifd_pkg::OP_IRQ_RET ||
          instr_word[13:8] == ifd_pkg::OP6_RET_LIT)
         base_cyc = ifd_pkg::CYC_TWO;
      if (instr_word[13:11] == ifd_pkg::OP3_JUMP || instr_word == ifd_pkg::OP_ACC_BRANCH ||
          instr_word[13:9] == ifd_pkg::OP5_REL_BRANCH)
         base_cyc = ifd_pkg::CYC_TWO;
   end

   // pointer pair from n field or from the indirect address
   always_comb
   begin
      ind_d = 1'b0;
      psel_d = instr_word[0];
      if (word_ptr_inc(instr_word))
      begin
         ind_d = 1'b1;
         psel_d = instr_word[ifd_pkg::PTR_INC_BIT];
      end
      else if (instr_word[13:8] == ifd_pkg::OP6_PTR_OFS)
      begin
         ind_d = 1'b1;
         psel_d = instr_word[ifd_pkg::PTR_OFS_BIT];
      end
      else if (word_ptr_ofs(instr_word))
         psel_d = instr_word[ifd_pkg::PTR_OFS_BIT];
      else if (word_class(instr_word) != ifd_pkg::IFD_CLS_LIT &&
               instr_word[13:7] != ifd_pkg::OP7_CLEAR_W)
         ind_d = (instr_word[6:0] == ifd_pkg::IND_ADDR0) ||
                 (instr_word[6:0] == ifd_pkg::IND_ADDR1);
      // pointer into program memory costs a cycle
      extra_d = ind_d && ptr_in_prog_mem[psel_d];
   end

   // A taken skip keeps its flushed cycle, so no word may land there
   assign skip_ext = (state_q == IFD_ST_FIRST) && is_skip_q && skip_taken;
   assign accept = cyc_end_w && instr_valid &&
                   (state_q == IFD_ST_IDLE || (cyc_left_q == 2'h1 && !skip_ext));

   // Sequencer: a word is only taken on a cycle boundary
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q <= IFD_ST_IDLE;
         cyc_left_q <= 2'h0;
         total_q <= 2'h0;
         busy_q <= 1'b0;
         taken_q <= 1'b0;
      end
      else
      begin
         taken_q <= accept;
         if (accept)
         begin
            state_q <= IFD_ST_FIRST;
            cyc_left_q <= base_cyc + {1'b0, extra_d};
            total_q <= base_cyc + {1'b0, extra_d};
            busy_q <= 1'b1;
         end
         else if (cyc_end_w)
         begin
            unique case (state_q)
               IFD_ST_IDLE:
               begin
                  state_q <= IFD_ST_IDLE;
               end
               IFD_ST_FIRST, IFD_ST_MORE:
               begin
                  // taken skip adds the flushed cycle
                  if (state_q == IFD_ST_FIRST && is_skip_q && skip_taken)
                  begin
                     state_q <= IFD_ST_MORE;
                     total_q <= total_q + 2'h1;
                  end
                  else if (cyc_left_q == 2'h1)
                  begin
                     state_q <= IFD_ST_IDLE;
                     busy_q <= 1'b0;
                     cyc_left_q <= 2'h0;
                  end
                  else
                  begin
                     state_q <= IFD_ST_MORE;
                     cyc_left_q <= cyc_left_q - 2'h1;
                  end
               end
               default:
               begin
                  state_q <= IFD_ST_IDLE;
                  busy_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Field capture; held stable for the whole instruction
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         class_q <= ifd_pkg::IFD_CLS_LIT;
         faddr_q <= 7'h00;
         dest_q <= 1'b0;
         bpos_q <= 3'h0;
         lit_q <= 11'h000;
         psel_q <= 1'b0;
         mode_q <= 2'h0;
         ind_q <= 1'b0;
         is_skip_q <= 1'b0;
      end
      else if (accept)
      begin
         class_q <= word_class(instr_word);
         faddr_q <= instr_word[6:0];
         dest_q <= instr_word[ifd_pkg::DEST_BIT];
         bpos_q <= instr_word[ifd_pkg::BITPOS_LSB +: 3];
         lit_q <= word_literal(instr_word);
         psel_q <= psel_d;
         mode_q <= word_ptr_inc(instr_word) ? instr_word[1:0] : 2'h0;
         ind_q <= ind_d;
         is_skip_q <= word_skips(instr_word);
      end
   end

   // Access enables; CLRW low bits unused so never looked at
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rd_q <= 1'b0;
         wrf_q <= 1'b0;
         wrw_q <= 1'b0;
      end
      else if (accept)
      begin
         unique case (word_class(instr_word))
            ifd_pkg::IFD_CLS_BYTE:
            begin
               rd_q <= 1'b1;
               wrf_q <= instr_word[ifd_pkg::DEST_BIT];
               wrw_q <= !instr_word[ifd_pkg::DEST_BIT];
            end
            ifd_pkg::IFD_CLS_BIT:
            begin
               // set/clear rewrite the file; tests only read
               rd_q <= 1'b1;
               wrf_q <= !instr_word[11];
               wrw_q <= 1'b0;
            end
            default:
            begin
               rd_q <= 1'b0;
               wrf_q <= 1'b0;
               wrw_q <= 1'b0;
            end
         endcase
      end
      else if (state_q == IFD_ST_IDLE)
      begin
         rd_q <= 1'b0;
         wrf_q <= 1'b0;
         wrw_q <= 1'b0;
      end
   end

   assign word_taken = taken_q;
   assign instr_busy = busy_q;
   assign instr_class = class_q;
   assign file_addr = faddr_q;
   assign dest_is_file = dest_q;
   assign bit_pos = bpos_q;
   assign literal = lit_q;
   assign ptr_select = psel_q;
   assign pointer_update_mode = mode_q;
   assign indirect_access = ind_q;
   assign file_read_en = rd_q;
   assign file_write_en = wrf_q;
   assign w_write_en = wrw_q;
   assign cycle_total = total_q;
   assign osc_phase = phase_w;
   assign cycle_end = cyc_end_w;

   // Checks
   a_call_two: assert property (@(posedge clock) disable iff (rst)
      accept && instr_word[13:11] == ifd_pkg::OP3_CALL && !extra_d
      |=> total_q == 2'h2)
      else $error("call not two cycles");
   a_ret_two: assert property (@(posedge clock) disable iff (rst)
      accept && instr_word == ifd_pkg::OP_RETURN |=> total_q == 2'h2)
      else $error("return not two cycles");
   a_plain_one: assert property (@(posedge clock) disable iff (rst)
      accept && instr_word[13:8] == 6'h07 && instr_word[6:1] != 6'h00
      |=> total_q == 2'h1)
      else $error("plain byte op not one cycle");
   a_ind_extra: assert property (@(posedge clock) disable iff (rst)
      accept && instr_word[13:7] == 7'h0F && instr_word[6:0] == 7'h00 &&
      ptr_in_prog_mem[0] |=> total_q == 2'h2 && ind_q)
      else $error("indirect program access missing extra cycle");
   a_dest_w: assert property (@(posedge clock) disable iff (rst)
      accept && word_class(instr_word) == ifd_pkg::IFD_CLS_BYTE
      |=> rd_q && (wrw_q == !dest_q) && (wrf_q == dest_q))
      else $error("destination select wrong");
   a_bit_field: assert property (@(posedge clock) disable iff (rst)
      accept |=> bpos_q == $past(instr_word[9:7]) && faddr_q == $past(instr_word[6:0]))
      else $error("bit or file field wrong");
   a_skip_extend: assert property (@(posedge clock) disable iff (rst)
      cyc_end_w && state_q == IFD_ST_FIRST && is_skip_q && skip_taken && !accept
      |=> (instr_busy && state_q == IFD_ST_MORE) [*4])
      else $error("taken skip did not extend");
   a_take_boundary: assert property (@(posedge clock) disable iff (rst)
      word_taken |-> $past(cyc_end_w))
      else $error("word taken off boundary");
   a_clrw_same: assert property (@(posedge clock) disable iff (rst)
      accept && instr_word[13:2] == 12'h040 |=> wrw_q && !wrf_q)
      else $error("don't-care bits changed decode");
   a_bra_lit: assert property (@(posedge clock) disable iff (rst)
      accept && instr_word[13:9] == ifd_pkg::OP5_REL_BRANCH
      |=> lit_q == {2'h0, $past(instr_word[8:0])} && total_q == 2'h2)
      else $error("branch literal or count wrong");

   c_skip: cover property (@(posedge clock) disable iff (rst)
      state_q == IFD_ST_FIRST && is_skip_q && skip_taken && cyc_end_w);
   c_three: cover property (@(posedge clock) disable iff (rst) total_q == 2'h3);
   c_back: cover property (@(posedge clock) disable iff (rst)
      word_taken ##4 word_taken);
endmodule

// *** hw/ifd_phase_gen.sv ***
// Four-phase instruction cycle generator
`timescale 1ns/1ps
module ifd_phase_gen
(
   input wire logic clock,
   input wire logic rst,
   output logic [1:0] phase,
   output logic cycle_end
);
   logic [1:0] phase_q;
   logic cycle_end_q;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         phase_q <= 2'h0;
         cycle_end_q <= 1'b0;
      end
      else
      begin
         phase_q <= phase_q + 2'h1;
         cycle_end_q <= (phase_q == 2'(ifd_pkg::OSC_PER_CYCLE - 2));
      end
   end

   assign phase = phase_q;
   assign cycle_end = cycle_end_q;

   a_end_period: assert property (@(posedge clock) disable iff (rst)
      cycle_end |=> !cycle_end [*3] ##1 cycle_end)
      else $error("cycle end pulse not every four clocks");
endmodule

// *** hw/ifd_pkg.sv ***
// Shared constants for the instruction format decoder
package ifd_pkg;
   localparam int WORD_W = 14;
   localparam int FILE_W = 7;
   localparam int LIT_W = 11;
   localparam int CYC_W = 2;
   // Field positions
   localparam int DEST_BIT = 7;
   localparam int BITPOS_LSB = 7;
   localparam int PTR_OFS_BIT = 6;
   localparam int PTR_INC_BIT = 2;
   // Timing
   localparam int OSC_PER_CYCLE = 4;
   localparam logic [CYC_W-1:0] CYC_ONE = 2'h1;
   localparam logic [CYC_W-1:0] CYC_TWO = 2'h2;
   // Indirect access register addresses, one per pointer pair
   localparam logic [FILE_W-1:0] IND_ADDR0 = 7'h00;
   localparam logic [FILE_W-1:0] IND_ADDR1 = 7'h01;
   // Top-two-bit class codes
   localparam logic [1:0] TOP_MISC = 2'h0;
   localparam logic [1:0] TOP_BIT = 2'h1;
   localparam logic [1:0] TOP_JUMP = 2'h2;
   localparam logic [1:0] TOP_LIT = 2'h3;
   // Full 14-bit control words
   localparam logic [13:0] OP_RETURN = 14'h0008;
   localparam logic [13:0] OP_IRQ_RET = 14'h0009;
   localparam logic [13:0] OP_ACC_CALL = 14'h000A;
   localparam logic [13:0] OP_ACC_BRANCH = 14'h000B;
   // Six-bit opcodes (bits 13:8)
   localparam logic [5:0] OP6_DEC_SKIP = 6'h0B;
   localparam logic [5:0] OP6_INC_SKIP = 6'h0F;
   localparam logic [5:0] OP6_RET_LIT = 6'h34;
   localparam logic [5:0] OP6_PTR_OFS = 6'h3F;
   localparam logic [5:0] OP6_ADD_PTR = 6'h31;
   localparam logic [5:0] OP6_LSL = 6'h35;
   localparam logic [5:0] OP6_LSR = 6'h36;
   localparam logic [5:0] OP6_ASR = 6'h37;
   localparam logic [5:0] OP6_SUBB = 6'h3B;
   localparam logic [5:0] OP6_ADDC = 6'h3D;
   // Prefixes of other lengths (3 to 11 bits)
   localparam logic [4:0] OP5_REL_BRANCH = 5'h19;
   localparam logic [3:0] OP4_SKIP_CLR = 4'h6;
   localparam logic [3:0] OP4_SKIP_SET = 4'h7;
   localparam logic [2:0] OP3_CALL = 3'h4;
   localparam logic [2:0] OP3_JUMP = 3'h5;
   localparam logic [8:0] OP9_BANK = 9'h001;
   localparam logic [6:0] OP7_PAGE = 7'h63;
   localparam logic [6:0] OP7_CLEAR_W = 7'h02;
   localparam logic [10:0] OP11_PTR_INC = 11'h002;

   typedef enum logic [1:0]
   {
      IFD_CLS_BYTE = 2'b00,
      IFD_CLS_BIT = 2'b01,
      IFD_CLS_LIT = 2'b10
   } ifd_class_t;
endpackage

// *** tb/ifd_fetch_model.sv ***
// Program word fetch path model feeding the decoder
`timescale 1ns/1ps
module ifd_fetch_model
(
   input wire logic clock,
   input wire logic rst,
   input wire logic offer,
   input wire logic [13:0] next_word,
   input wire logic word_taken,
   output logic [13:0] instr_word,
   output logic instr_valid
);
   initial
   begin
      instr_valid = 1'b0;
      instr_word = 14'h0000;
   end

   // Hold word until accepted; a released bus toggles so stale data never matches
   // whole word
   always @(negedge clock)
   begin
      if (instr_valid && word_taken)
      begin
         instr_valid <= 1'b0;
         instr_word <= ~instr_word;
      end
      else if (!instr_valid && offer && !rst)
      begin
         instr_valid <= 1'b1;
         instr_word <= next_word;
      end
      else if (!instr_valid)
         instr_word <= ~instr_word;
   end
endmodule

// *** tb/instruction_format_decoder_tb.sv ***
// Self-checking bench for the instruction format decoder
`timescale 1ns/1ps
module instruction_format_decoder_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic offer = 1'b0;
   logic [13:0] next_word = 14'h0000;
   logic [13:0] instr_word;
   logic instr_valid;
   logic skip_taken = 1'b0;
   logic [1:0] ptr_in_prog_mem = 2'h0;
   logic word_taken, instr_busy, dest_is_file, ptr_select, indirect_access;
   logic file_read_en, file_write_en, w_write_en, cycle_end;
   ifd_pkg::ifd_class_t instr_class;
   logic [6:0] file_addr;
   logic [2:0] bit_pos;
   logic [10:0] literal;
   logic [1:0] pointer_update_mode, cycle_total, osc_phase;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;

   // 200 MHz core clock
   always #2.5 clock = ~clock;

   ifd_fetch_model i_ifd_fetch_model (.clock(clock), .rst(rst), .offer(offer),
      .next_word(next_word), .word_taken(word_taken), .instr_word(instr_word),
      .instr_valid(instr_valid));

   ifd_decoder i_ifd_decoder (.clock(clock), .rst(rst), .instr_word(instr_word),
      .instr_valid(instr_valid), .skip_taken(skip_taken),
      .ptr_in_prog_mem(ptr_in_prog_mem), .word_taken(word_taken), .instr_busy(instr_busy),
      .instr_class(instr_class), .file_addr(file_addr), .dest_is_file(dest_is_file),
      .bit_pos(bit_pos), .literal(literal), .ptr_select(ptr_select),
      .pointer_update_mode(pointer_update_mode), .indirect_access(indirect_access),
      .file_read_en(file_read_en), .file_write_en(file_write_en), .w_write_en(w_write_en),
      .cycle_total(cycle_total), .osc_phase(osc_phase), .cycle_end(cycle_end));

   task automatic final_report();
      if (bad_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard, well above the expected run length
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         final_report();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Offer one word and return at the falling edge where it shows as taken
   task automatic take(input logic [13:0] w, input logic [1:0] pm, input logic sk);
      int n;
      n = 0;
      ptr_in_prog_mem = pm;
      skip_taken = sk;
      next_word = w;
      offer = 1'b1;
      while (word_taken !== 1'b1 && n < 64)
      begin
         @(negedge clock);
         n++;
      end
      offer = 1'b0;
      check("word_taken", word_taken, 1'b1);
      check("instr_busy", instr_busy, 1'b1);
   endtask

   // Count instruction cycles until the decoder goes idle
   task automatic finish(input logic [1:0] exp);
      int n;
      int ends;
      logic [1:0] tot;
      n = 0;
      ends = 0;
      tot = cycle_total;
      while (instr_busy === 1'b1 && n < 64)
      begin
         if (cycle_end === 1'b1)
            ends++;
         tot = cycle_total;
         @(negedge clock);
         n++;
      end
      check("cycle_total", tot, exp);
      check("cycle_count", ends[15:0], exp);
   endtask

   task automatic phase_seq();
      logic [1:0] p;
      int i;
      p = osc_phase;
      for (i = 0; i < 9; i++)
      begin
         @(negedge clock);
         p = p + 2'h1;
         check("osc_phase", osc_phase, p);
         check("cycle_end", cycle_end, p == 2'h3);
      end
   endtask

   // Byte ops: both destinations, a clear and a plain store
   task automatic byte_ops();
      logic [13:0] w [4] = '{14'h07FF, 14'h077F, 14'h01A5, 14'h00A5};
      int i;
      for (i = 0; i < 4; i++)
      begin
         take(w[i], 2'h0, 1'b0);
         check("class", instr_class, ifd_pkg::IFD_CLS_BYTE);
         check("file_addr", file_addr, w[i][6:0]);
         check("dest", dest_is_file, w[i][7]);
         check("read_en", file_read_en, 1'b1);
         check("file_wr", file_write_en, w[i][7]);
         check("w_wr", w_write_en, !w[i][7]);
         finish(2'h1);
      end
   endtask

   task automatic bit_ops();
      take(14'h17D5, 2'h0, 1'b0);
      check("class", instr_class, ifd_pkg::IFD_CLS_BIT);
      check("bit_pos", bit_pos, 3'h7);
      check("file_addr", file_addr, 7'h55);
      check("file_wr", file_write_en, 1'b1);
      finish(2'h1);
      take(14'h1800, 2'h0, 1'b0);
      check("bit_pos", bit_pos, 3'h0);
      finish(2'h1);
      take(14'h1C7F, 2'h0, 1'b1);
      check("file_wr", file_write_en, 1'b0);
      finish(2'h2);
      take(14'h0BA0, 2'h0, 1'b1);
      finish(2'h2);
      take(14'h0FA0, 2'h0, 1'b0);
      finish(2'h1);
   endtask

   // Literal and control words with their literal fields and cycle counts
   task automatic lit_ops();
      logic [13:0] w [11] = '{14'h30A5, 14'h27FF, 14'h2923, 14'h31D5, 14'h003F, 14'h33AB,
         14'h34CC, 14'h0008, 14'h0009, 14'h000A, 14'h000B};
      logic [10:0] k [7] = '{11'h0A5, 11'h7FF, 11'h123, 11'h055, 11'h01F, 11'h1AB, 11'h0CC};
      logic [1:0] c [11] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
      int i;
      for (i = 0; i < 11; i++)
      begin
         take(w[i], 2'h3, 1'b0);
         check("class", instr_class, ifd_pkg::IFD_CLS_LIT);
         check("read_en", file_read_en, 1'b0);
         if (i < 7)
            check("literal", literal, k[i]);
         finish(c[i]);
      end
   endtask

   task automatic ptr_ops();
      int i;
      take(14'h316A, 2'h0, 1'b0);
      check("ptr_sel", ptr_select, 1'b1);
      check("literal", literal, 11'h02A);
      finish(2'h1);
      // Offset form goes through pair 1, which points at program memory
      take(14'h3F45, 2'h2, 1'b0);
      check("ptr_sel", ptr_select, 1'b1);
      check("indirect", indirect_access, 1'b1);
      check("literal", literal, 11'h005);
      finish(2'h2);
      for (i = 0; i < 8; i++)
      begin
         take({11'h002, i[2:0]}, 2'h0, 1'b0);
         check("ptr_sel", ptr_select, i[2]);
         check("mode", pointer_update_mode, i[1:0]);
         finish(2'h1);
      end
   endtask

   // Indirect access adds a cycle only when that pair points at program memory
   task automatic indirect_ops();
      take(14'h0781, 2'h2, 1'b0);
      check("indirect", indirect_access, 1'b1);
      finish(2'h2);
      take(14'h0781, 2'h1, 1'b0);
      finish(2'h1);
      // Call has no file operand, so no extra cycle
      take(14'h2123, 2'h3, 1'b0);
      finish(2'h2);
      // Taken skip through a program-memory pointer: one plus one plus one
      take(14'h0B80, 2'h1, 1'b1);
      finish(2'h3);
   endtask

   // Clear-W decodes the same whatever its don't-care bits hold
   task automatic dont_care();
      logic [13:0] w [2] = '{14'h0100, 14'h0103};
      int i;
      for (i = 0; i < 2; i++)
      begin
         take(w[i], 2'h3, 1'b0);
         check("class", instr_class, ifd_pkg::IFD_CLS_BYTE);
         check("indirect", indirect_access, 1'b0);
         check("w_wr", w_write_en, 1'b1);
         check("file_wr", file_write_en, 1'b0);
         finish(2'h1);
      end
   endtask

   // Word offered during a taken skip waits out the flushed cycle
   task automatic skip_queue();
      int n;
      int j;
      take(14'h1C7F, 2'h0, 1'b1);
      next_word = 14'h30A5;
      offer = 1'b1;
      for (j = 0; j < 2; j++)
      begin
         n = 1;
         @(negedge clock);
         while (word_taken !== 1'b1 && n < 64)
         begin
            @(negedge clock);
            n++;
         end
         check("take_gap", n[15:0], (j == 0) ? 16'h0008 : 16'h0004);
      end
      offer = 1'b0;
      check("class", instr_class, ifd_pkg::IFD_CLS_LIT);
      finish(2'h1);
   endtask

   // Reset in mid-instruction returns everything to idle
   task automatic reset_mid();
      take(14'h27FF, 2'h0, 1'b0);
      rst = 1'b1;
      @(negedge clock);
      check("rst_busy", instr_busy, 1'b0);
      check("rst_taken", word_taken, 1'b0);
      check("rst_class", instr_class, ifd_pkg::IFD_CLS_LIT);
      check("rst_read", file_read_en, 1'b0);
      check("rst_phase", osc_phase, 2'h0);
      rst = 1'b0;
      take(14'h07FF, 2'h0, 1'b0);
      finish(2'h1);
   endtask

   initial
   begin
      repeat (16) @(negedge clock);
      check("reset_busy", instr_busy, 1'b0);
      rst = 1'b0;
      phase_seq();
      byte_ops();
      bit_ops();
      lit_ops();
      ptr_ops();
      indirect_ops();
      dont_care();
      skip_queue();
      reset_mid();
      final_report();
   end
endmodule
